// ==== common/isd_params.svh ====
// Purpose: constants for the initial speed detect settings block
// Assumes: 50 MHz clock, AXI4-Lite with 32-bit data
// Notes:   offsets are byte addresses
`ifndef ISD_PARAMS_SVH
`define ISD_PARAMS_SVH

`define ISD_ADDR_W          8
`define ISD_OFS_SETTINGS    8'h00
`define ISD_OFS_STATUS      8'h04
`define ISD_SETTINGS_RST    32'h00000000

`define ISD_PARITY_BIT      31
`define ISD_DETECT_BIT      30
`define ISD_BRAKE_BIT       29
`define ISD_COAST_BIT       28
`define ISD_REVERSE_BIT     27
`define ISD_RESYNC_BIT      26
`define ISD_RESYNC_LVL_LSB  22
`define ISD_FET_PAT_BIT     21
`define ISD_BRAKE_DURATION_CODE_LSB    13
`define ISD_COAST_TIME_LSB  9
`define ISD_STILL_LVL_LSB   6

`define ISD_ST_STATE_LSB    0
`define ISD_ST_OUTCOME_LSB  4
`define ISD_ST_BUSY_BIT     8

`define ISD_CLK_NS          20
`define ISD_MS_NS           1000000

`define ISD_T0_MS   14'd10
`define ISD_T1_MS   14'd50
`define ISD_T2_MS   14'd100
`define ISD_T3_MS   14'd200
`define ISD_T4_MS   14'd300
`define ISD_T5_MS   14'd400
`define ISD_T6_MS   14'd500
`define ISD_T7_MS   14'd750
`define ISD_T8_MS   14'd1000
`define ISD_T9_MS   14'd2000
`define ISD_TA_MS   14'd3000
`define ISD_TB_MS   14'd4000
`define ISD_TC_MS   14'd5000
`define ISD_TD_MS   14'd7500
`define ISD_TE_MS   14'd10000
`define ISD_TF_MS   14'd15000

`define ISD_PCT_STEP     7'd5
`define ISD_PCT_HI_BASE  7'd70
`define ISD_PCT_HI_STEP  7'd10
`define ISD_PCT_HI_CODE  4'hC

`define ISD_MV_0  11'd50
`define ISD_MV_1  11'd75
`define ISD_MV_2  11'd100
`define ISD_MV_3  11'd250
`define ISD_MV_4  11'd500
`define ISD_MV_5  11'd750
`define ISD_MV_6  11'd1000
`define ISD_MV_7  11'd1500

`endif

// ==== common/isd_pkg.sv ====
// Purpose: types for the initial speed detect settings block
// Assumes: isd_params.svh supplies the figures
// Notes:   duration lookup shared by the timer and the top
`include "isd_params.svh"
package isd_pkg;
  typedef enum logic [2:0] {ISD_IDLE, ISD_DETECT, ISD_COAST, ISD_BRAKE, ISD_DONE} isd_state_t;
  typedef enum logic [1:0] {ISD_OUT_NONE, ISD_OUT_START, ISD_OUT_RESYNC, ISD_OUT_REVERSE} isd_outcome_t;

  function automatic logic [13:0] isd_dur_ms(input logic [3:0] code);
    unique case (code)
      4'h0: isd_dur_ms = `ISD_T0_MS;
      4'h1: isd_dur_ms = `ISD_T1_MS;
      4'h2: isd_dur_ms = `ISD_T2_MS;
      4'h3: isd_dur_ms = `ISD_T3_MS;
      4'h4: isd_dur_ms = `ISD_T4_MS;
      4'h5: isd_dur_ms = `ISD_T5_MS;
      4'h6: isd_dur_ms = `ISD_T6_MS;
      4'h7: isd_dur_ms = `ISD_T7_MS;
      4'h8: isd_dur_ms = `ISD_T8_MS;
      4'h9: isd_dur_ms = `ISD_T9_MS;
      4'hA: isd_dur_ms = `ISD_TA_MS;
      4'hB: isd_dur_ms = `ISD_TB_MS;
      4'hC: isd_dur_ms = `ISD_TC_MS;
      4'hD: isd_dur_ms = `ISD_TD_MS;
      4'hE: isd_dur_ms = `ISD_TE_MS;
      4'hF: isd_dur_ms = `ISD_TF_MS;
    endcase
  endfunction : isd_dur_ms
endpackage : isd_pkg

// ==== common/isd_sub_if.sv ====
// Purpose: links the sequencer to its timer and level decoder
// Assumes: one clock domain
// Notes:   run is a level; expired holds until run drops
`timescale 1ns/1ps
interface isd_sub_if;
  logic        run;
  logic [3:0]  code;
  logic        expired;
  logic [3:0]  speed_code;
  logic [2:0]  still_code;
  logic [6:0]  speed_pct;
  logic [10:0] still_mv;
  modport ctl (output run, output code, input expired,
               output speed_code, output still_code, input speed_pct, input still_mv);
  modport tmr (input run, input code, output expired);
  modport dec (input speed_code, input still_code, output speed_pct, output still_mv);
endinterface : isd_sub_if

// ==== hdl/isd_timer.sv ====
// Purpose: millisecond duration timer for brake and coast phases
// Assumes: code is steady while run is high
// Notes:   expired rises dur*MS_CYCLES edges after the load edge
`timescale 1ns/1ps
`include "isd_params.svh"
module isd_timer
  import isd_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `ISD_MS_NS / `ISD_CLK_NS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  isd_sub_if.tmr    sub
);
  logic [31:0] pre;
  logic [13:0] ms_left;
  logic        loaded;

  always_ff @(posedge clk) begin
    if (!rst_n || !sub.run) begin
      pre         <= 32'h00000000;
      ms_left     <= 14'h0000;
      loaded      <= 1'b0;
      sub.expired <= 1'b0;
    end else if (!loaded) begin
      pre     <= MS_CYCLES - 1;
      ms_left <= isd_dur_ms(sub.code);
      loaded  <= 1'b1;
    end else if (!sub.expired) begin
      if (pre == 32'h00000000) begin
        pre <= MS_CYCLES - 1;
        if (ms_left == 14'h0001) begin
          sub.expired <= 1'b1;
        end
        ms_left <= ms_left - 14'h0001;
      end else begin
        pre <= pre - 32'h00000001;
      end
    end
  end
endmodule : isd_timer

// ==== hdl/isd_level_decode.sv ====
// Purpose: turns threshold codes into percent and millivolt levels
// Assumes: codes come from the settings register
// Notes:   purely combinational
`timescale 1ns/1ps
`include "isd_params.svh"
module isd_level_decode
  import isd_pkg::*;
(
  isd_sub_if.dec sub
);
  always_comb begin
    if (sub.speed_code < `ISD_PCT_HI_CODE) begin
      sub.speed_pct = 7'(`ISD_PCT_STEP * ({3'h0, sub.speed_code} + 7'd1));
    end else begin
      sub.speed_pct = 7'(`ISD_PCT_HI_BASE + `ISD_PCT_HI_STEP * {3'h0, sub.speed_code - `ISD_PCT_HI_CODE});
    end
  end

  always_comb begin
    unique case (sub.still_code)
      3'h0: sub.still_mv = `ISD_MV_0;
      3'h1: sub.still_mv = `ISD_MV_1;
      3'h2: sub.still_mv = `ISD_MV_2;
      3'h3: sub.still_mv = `ISD_MV_3;
      3'h4: sub.still_mv = `ISD_MV_4;
      3'h5: sub.still_mv = `ISD_MV_5;
      3'h6: sub.still_mv = `ISD_MV_6;
      3'h7: sub.still_mv = `ISD_MV_7;
    endcase
  end
endmodule : isd_level_decode

// ==== hdl/isd_top.sv ====
// Purpose: initial speed detect settings register and startup sequencer
// Assumes: bemf_mv, speed_pct and motor_forward come from same-clock logic
// Notes:   settings are captured at start and held for the whole sequence
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "isd_params.svh"

// Contract
// - Bit 30 turns initial speed detection on when 1 and off when 0, resetting to 0.
// - Bit 29 permits braking when 1 and forbids it when 0, resetting to 0.
// - Bit 28 permits a high-impedance coast whose length is chosen by bits 12-9 with the brake time codes.
// - Bit 27 permits driving the motor out of reverse rotation when 1, resetting to 0.
// - Bit 26 permits resynchronizing to a forward-turning motor when 1, resetting to 0.
// - Bits 25-22 set the least forward speed for resync, 5% to 60% in 5% steps then 70% to 100%.
// - With bit 21 at 0 the brake turns on all three high-side transistors.
// - With bit 21 at 1 the brake turns on all three low-side transistors instead.
// - Bits 16-13 choose the brake length from 10 ms up to 15 s.
// - Bits 8-6 choose the back-EMF level below which the motor counts as stationary.
module isd_top
  import isd_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `ISD_MS_NS / `ISD_CLK_NS
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`ISD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`ISD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   start_req,
  input  wire logic                   motor_forward,
  input  wire logic [10:0]            bemf_mv,
  input  wire logic [6:0]             speed_pct,
  output logic [2:0]                  hs_on,
  output logic [2:0]                  ls_on,
  output logic                        outputs_hiz,
  output logic                        busy,
  output logic                        done,
  output logic [1:0]                  outcome
);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [31:0]            initial_speed_detect_settings;
  logic [31:0]            snap;
  isd_state_t             st;
  isd_state_t             next_st;
  isd_outcome_t           res;
  isd_outcome_t           next_res;
  logic                   aw_held;
  logic                   w_held;
  logic [`ISD_ADDR_W-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic [31:0]            status;

  isd_sub_if sub ();

  isd_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .sub   (sub.tmr)
  );

  isd_level_decode u_decode (
    .sub (sub.dec)
  );

  // named fields of the captured settings
  logic       speed_detect_on;
  logic       brake_allowed;
  logic       coast_allowed;
  logic       reverse_recovery_allowed;
  logic       forward_resync_allowed;
  logic [3:0] forward_resync_speed_level;
  logic       brake_fet_pattern;
  logic [3:0] brake_duration_code;
  logic [3:0] coast_duration_code;
  logic [2:0] standstill_bemf_level;

  assign speed_detect_on            = snap[`ISD_DETECT_BIT];
  assign brake_allowed              = snap[`ISD_BRAKE_BIT];
  assign coast_allowed              = snap[`ISD_COAST_BIT];
  assign reverse_recovery_allowed   = snap[`ISD_REVERSE_BIT];
  assign forward_resync_allowed     = snap[`ISD_RESYNC_BIT];
  assign forward_resync_speed_level = snap[`ISD_RESYNC_LVL_LSB +: 4];
  assign brake_fet_pattern          = snap[`ISD_FET_PAT_BIT];
  assign brake_duration_code        = snap[`ISD_BRAKE_DURATION_CODE_LSB +: 4];
  assign coast_duration_code        = snap[`ISD_COAST_TIME_LSB +: 4];
  assign standstill_bemf_level      = snap[`ISD_STILL_LVL_LSB +: 3];

  // bus write path: address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (aw_held && w_held) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[`ISD_ADDR_W-1:2] == 6'(`ISD_OFS_SETTINGS >> 2)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // every bit, parity and reserved included, is plain storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      initial_speed_detect_settings <= `ISD_SETTINGS_RST;
    end else if (aw_held && w_held && aw_addr[`ISD_ADDR_W-1:2] == 6'(`ISD_OFS_SETTINGS >> 2)) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) begin
          initial_speed_detect_settings[8*i +: 8] <= w_data[8*i +: 8];
        end
      end
    end
  end

  // bus read path
  always_comb begin
    status = 32'h00000000;
    status[`ISD_ST_STATE_LSB +: 3]   = st;
    status[`ISD_ST_OUTCOME_LSB +: 2] = res;
    status[`ISD_ST_BUSY_BIT]         = busy;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[`ISD_ADDR_W-1:2] == 6'(`ISD_OFS_SETTINGS >> 2)) begin
        s_axi_rdata <= initial_speed_detect_settings;
        s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_araddr[`ISD_ADDR_W-1:2] == 6'(`ISD_OFS_STATUS >> 2)) begin
        s_axi_rdata <= status;
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // settings are frozen for a sequence so a mid-run write cannot tear it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap <= `ISD_SETTINGS_RST;
    end else if (st == ISD_IDLE && start_req) begin
      snap <= initial_speed_detect_settings;
    end
  end

  assign sub.code       = (st == ISD_BRAKE) ? brake_duration_code : coast_duration_code;
  assign sub.run        = (st == ISD_BRAKE || st == ISD_COAST) && !sub.expired;
  assign sub.speed_code = forward_resync_speed_level;
  assign sub.still_code = standstill_bemf_level;

  always_comb begin
    next_st  = st;
    next_res = res;
    unique case (st)
      ISD_IDLE: begin
        if (start_req) begin
          next_st = ISD_DETECT;
        end
      end
      ISD_DETECT: begin
        next_st = ISD_DONE;
        if (!speed_detect_on) begin
          next_res = ISD_OUT_START;
        end else if (bemf_mv < sub.still_mv) begin
          next_res = ISD_OUT_START;
        end else if (motor_forward && forward_resync_allowed && speed_pct >= sub.speed_pct) begin
          next_res = ISD_OUT_RESYNC;
        end else if (!motor_forward && reverse_recovery_allowed) begin
          next_res = ISD_OUT_REVERSE;
        end else if (coast_allowed) begin
          next_st = ISD_COAST;
        end else if (brake_allowed) begin
          next_st = ISD_BRAKE;
        end else begin
          next_res = ISD_OUT_START;
        end
      end
      ISD_COAST: begin
        if (sub.expired) begin
          next_st  = brake_allowed ? ISD_BRAKE : ISD_DONE;
          next_res = ISD_OUT_START;
        end
      end
      ISD_BRAKE: begin
        if (sub.expired) begin
          next_st  = ISD_DONE;
          next_res = ISD_OUT_START;
        end
      end
      ISD_DONE: begin
        next_st = ISD_IDLE;
      end
      default: begin
        next_st = ISD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st  <= ISD_IDLE;
      res <= ISD_OUT_NONE;
    end else begin
      st  <= next_st;
      res <= (st == ISD_IDLE && start_req) ? ISD_OUT_NONE : next_res;
    end
  end

  // driver outputs registered from the next state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_on       <= 3'h0;
      ls_on       <= 3'h0;
      outputs_hiz <= 1'b0;
      busy        <= 1'b0;
      done        <= 1'b0;
      outcome     <= 2'h0;
    end else begin
      hs_on       <= (next_st == ISD_BRAKE && !brake_fet_pattern) ? 3'h7 : 3'h0;
      ls_on       <= (next_st == ISD_BRAKE && brake_fet_pattern) ? 3'h7 : 3'h0;
      outputs_hiz <= next_st == ISD_COAST;
      busy        <= next_st != ISD_IDLE;
      done        <= next_st == ISD_DONE;
      outcome     <= (next_st == ISD_DONE) ? next_res : outcome;
    end
  end

  // helper: cycles spent in the brake and coast states
  logic [31:0] phase_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || next_st != st) begin
      phase_cnt <= 32'h00000000;
    end else begin
      phase_cnt <= phase_cnt + 32'h00000001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_detect_off;
    st == ISD_DETECT && !speed_detect_on |=> st == ISD_DONE && done && outcome == ISD_OUT_START;
  endproperty
  a_detect_off: assert property (p_detect_off) else $error("detect off did not finish at once");

  property p_brake_gate;
    (hs_on != 3'h0 || ls_on != 3'h0) |-> brake_allowed;
  endproperty
  a_brake_gate: assert property (p_brake_gate) else $error("brake driven while not allowed");

  property p_coast_len;
    st == ISD_COAST && sub.expired |-> coast_allowed && outputs_hiz
      && phase_cnt == 32'(isd_dur_ms(coast_duration_code)) * MS_CYCLES + 32'h00000001;
  endproperty
  a_coast_len: assert property (p_coast_len) else $error("coast length wrong");

  property p_reverse;
    $rose(done) && outcome == ISD_OUT_REVERSE |-> reverse_recovery_allowed && !$past(motor_forward);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse outcome not allowed");

  property p_resync;
    st == ISD_DETECT && speed_detect_on && bemf_mv >= sub.still_mv && motor_forward
      && forward_resync_allowed && speed_pct >= sub.speed_pct |=> st == ISD_DONE && res == ISD_OUT_RESYNC;
  endproperty
  a_resync: assert property (p_resync) else $error("resync not taken");

  property p_resync_level;
    $rose(done) && outcome == ISD_OUT_RESYNC |-> forward_resync_allowed
      && $past(speed_pct) >= $past(sub.speed_pct);
  endproperty
  a_resync_level: assert property (p_resync_level) else $error("resync below speed level");

  property p_high_side;
    hs_on != 3'h0 |-> hs_on == 3'h7 && ls_on == 3'h0 && !brake_fet_pattern && !outputs_hiz;
  endproperty
  a_high_side: assert property (p_high_side) else $error("high side brake pattern wrong");

  property p_low_side;
    ls_on != 3'h0 |-> ls_on == 3'h7 && hs_on == 3'h0 && brake_fet_pattern;
  endproperty
  a_low_side: assert property (p_low_side) else $error("low side brake pattern wrong");

  property p_brake_len;
    st == ISD_BRAKE && sub.expired |->
      phase_cnt == 32'(isd_dur_ms(brake_duration_code)) * MS_CYCLES + 32'h00000001;
  endproperty
  a_brake_len: assert property (p_brake_len) else $error("brake length wrong");

  property p_still;
    st == ISD_DETECT && speed_detect_on && bemf_mv < sub.still_mv |=> done && outcome == ISD_OUT_START;
  endproperty
  a_still: assert property (p_still) else $error("stationary motor not started");

  property p_storage;
    s_axi_bvalid && !$past(s_axi_bvalid) && $past(w_strb) == 4'hF && s_axi_bresp == RESP_OKAY
      |-> initial_speed_detect_settings == $past(w_data);
  endproperty
  a_storage: assert property (p_storage) else $error("settings word not stored whole");
endmodule : isd_top

// ==== bench/tb_isd_top.sv ====
// Purpose: self-checking bench for the speed detect settings block
// Assumes: MS_CYCLES shortened to 2; reset held for 20 cycles
// Notes:   phase lengths are counted from samples taken 1 ns after each edge
`timescale 1ns/1ps
`include "isd_params.svh"
module tb_isd_top
  import isd_pkg::*;
;
  localparam int unsigned MS  = 2;
  localparam logic [31:0] DET = 32'h1 << `ISD_DETECT_BIT;
  localparam logic [31:0] BRK = 32'h1 << `ISD_BRAKE_BIT;
  localparam logic [31:0] CST = 32'h1 << `ISD_COAST_BIT;
  localparam logic [31:0] REV = 32'h1 << `ISD_REVERSE_BIT;
  localparam logic [31:0] RSY = 32'h1 << `ISD_RESYNC_BIT;
  localparam logic [31:0] PAT = 32'h1 << `ISD_FET_PAT_BIT;
  localparam logic [31:0] RSV = 32'h801E_0000;
  localparam logic [10:0] STILL_MV [5] = '{11'h032, 11'h04B, 11'h064, 11'h0FA, 11'h1F4};

  logic        clk, rst_n, start_req, motor_forward;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, outcome;
  logic [10:0] bemf_mv;
  logic [6:0]  speed_pct;
  logic [2:0]  hs_on, ls_on;
  logic        outputs_hiz, busy, done;
  int          fail_count, samples_checked, cycles;

  isd_top #(.MS_CYCLES(MS)) u_isd_top (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .start_req, .motor_forward, .bemf_mv, .speed_pct, .hs_on, .ls_on, .outputs_hiz, .busy,
    .done, .outcome
  );

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR %0t: run did not finish in time", $time);
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, got;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      #1;
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!(ta || !s_axi_awvalid) || !(tw || !s_axi_wvalid));
    do begin
      #1;
      got = s_axi_bvalid;
      r   = s_axi_bresp;
      @(posedge clk);
    end while (got !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      #1;
      got = s_axi_arready;
      @(posedge clk);
    end while (got !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do begin
      #1;
      got = s_axi_rvalid;
      d   = s_axi_rdata;
      r   = s_axi_rresp;
      @(posedge clk);
    end while (got !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask : axi_read

  // eo bit 2 set means the outcome code is not judged
  task automatic run_seq(input logic [31:0] cfg, input logic fwd, input logic [10:0] mv, input logic [6:0] pct,
                         input logic [2:0] eo, input int e_hiz, input int e_hs, input int e_ls);
    logic [1:0] r;
    int         n_hiz, n_hs, n_ls, k;
    axi_write(`ISD_OFS_SETTINGS, cfg, r);
    check(r, 32'h0);
    motor_forward <= fwd;
    bemf_mv       <= mv;
    speed_pct     <= pct;
    start_req     <= 1'h1;
    @(posedge clk);
    start_req <= 1'h0;
    n_hiz = 0;
    n_hs  = 0;
    n_ls  = 0;
    k     = 0;
    do begin
      #1;
      n_hiz += (outputs_hiz === 1'h1);
      n_hs  += (hs_on === 3'h7);
      n_ls  += (ls_on === 3'h7);
      k++;
      if (done !== 1'h1) @(posedge clk);
    end while (done !== 1'h1 && k < 2000);
    check(done, 32'h1);
    check(busy, 32'h1);
    if (!eo[2]) check(outcome, eo[1:0]);
    check(n_hiz, e_hiz);
    check(n_hs, e_hs);
    check(n_ls, e_ls);
    @(posedge clk);
    #1;
    check(busy, 32'h0);
  endtask : run_seq

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(`ISD_OFS_SETTINGS, d, r);
    check(d, `ISD_SETTINGS_RST);
    axi_write(`ISD_OFS_SETTINGS, 32'hFFFF_FFFF, r);
    axi_read(`ISD_OFS_SETTINGS, d, r);
    check(d, 32'hFFFF_FFFF);
    axi_write(8'h08, 32'h1234_5678, r);
    check(r, 32'h2);
    axi_read(8'h08, d, r);
    check(d, 32'h0);
    check(r, 32'h2);
    axi_write(`ISD_OFS_STATUS, 32'h0, r);
    check(r, 32'h2);
  endtask : t_regs

  task automatic t_detect_off();
    logic [31:0] d;
    logic [1:0]  r;
    run_seq(REV | CST | BRK | RSY, 1'h0, 11'h7FF, 7'h0, 3'h1, 0, 0, 0);
    axi_read(`ISD_OFS_STATUS, d, r);
    check(d, 32'h1 << `ISD_ST_OUTCOME_LSB);
    check(r, 32'h0);
  endtask : t_detect_off

  task automatic t_standstill();
    for (int c = 0; c < 5; c++) begin
      run_seq(DET | REV | (32'(c) << `ISD_STILL_LVL_LSB), 1'h0, STILL_MV[c] - 11'h1, 7'h0, 3'h1, 0, 0, 0);
      run_seq(DET | REV | (32'(c) << `ISD_STILL_LVL_LSB), 1'h0, STILL_MV[c], 7'h0, 3'h3, 0, 0, 0);
    end
    run_seq(DET, 1'h0, 11'h7FF, 7'h0, 3'h1, 0, 0, 0);
  endtask : t_standstill

  task automatic t_resync();
    logic [6:0] p;
    for (int c = 0; c < 16; c++) begin
      p = (c < 12) ? 7'(5 * (c + 1)) : 7'(70 + 10 * (c - 12));
      run_seq(DET | RSY | (32'(c) << `ISD_RESYNC_LVL_LSB), 1'h1, 11'h7FF, p, 3'h2, 0, 0, 0);
      run_seq(DET | RSY | (32'(c) << `ISD_RESYNC_LVL_LSB), 1'h1, 11'h7FF, p - 7'h1, 3'h1, 0, 0, 0);
    end
    run_seq(DET, 1'h1, 11'h7FF, 7'h64, 3'h1, 0, 0, 0);
  endtask : t_resync

  task automatic t_brake();
    run_seq(DET | BRK, 1'h0, 11'h7FF, 7'h0, 3'h1, 0, 10 * MS + 2, 0);
    run_seq(DET | BRK | PAT | (32'h1 << `ISD_BRAKE_DURATION_CODE_LSB), 1'h0, 11'h7FF, 7'h0, 3'h1, 0, 0, 50 * MS + 2);
    run_seq(DET | PAT, 1'h0, 11'h7FF, 7'h0, 3'h1, 0, 0, 0);
  endtask : t_brake

  task automatic t_coast();
    run_seq(DET | CST | BRK | RSV | (32'h1 << `ISD_COAST_TIME_LSB), 1'h0, 11'h7FF, 7'h0, 3'h1,
            50 * MS + 2, 10 * MS + 2, 0);
    run_seq(DET | CST, 1'h0, 11'h7FF, 7'h0, 3'h1, 10 * MS + 2, 0, 0);
  endtask : t_coast

  initial begin
    rst_n         = 1'h0;
    start_req     = 1'h0;
    motor_forward = 1'h0;
    bemf_mv       = 11'h0;
    speed_pct     = 7'h0;
    s_axi_awaddr  = 8'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'h0;
    s_axi_bready  = 1'h0;
    s_axi_araddr  = 8'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready  = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_detect_off();
    t_standstill();
    t_resync();
    t_brake();
    t_coast();
    print_verdict();
  end
endmodule : tb_isd_top
